// ==== shared/spm_consts.vh ====
// constant definitions for the sleep and clock gating block
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH
// control register word index, and byte addresses on the register bus (four times the index)
`define SPM_IDX_CTRL 8'h35
`define SPM_ADDR_CTRL 8'hD4
`define SPM_ADDR_GATE 8'hD8
`define SPM_ADDR_ANA 8'hDC
`define SPM_ADDR_DIS0 8'hE0
`define SPM_ADDR_DIS1 8'hE4
`define SPM_ADDR_STAT 8'hE8
// core control register fields
`define SPM_CTRL_SE 5
`define SPM_CTRL_SK_HI 4
`define SPM_CTRL_SK_LO 3
`define SPM_CTRL_MASK 8'h7B
`define SPM_CTRL_RST 8'h00
// clock gate register fields
`define SPM_GATE_TIM1 3
`define SPM_GATE_TIM0 2
`define SPM_GATE_SER 1
`define SPM_GATE_CONV 0
`define SPM_GATE_MASK 8'h0F
`define SPM_GATE_RST 8'h00
// analog control register fields
`define SPM_ANA_CONV_EN 0
`define SPM_ANA_CMP_EN 1
`define SPM_ANA_CMP_BG 2
`define SPM_ANA_WDT_EN 3
`define SPM_ANA_MASK 8'h0F
// sleep kinds
`define SPM_SK_IDLE 2'h0
`define SPM_SK_NOISE 2'h1
`define SPM_SK_PDOWN 2'h2
`define SPM_SK_STBY 2'h3
// reference start-up time in ns
`define SPM_REF_START_NS 1000
`define SPM_CLK_NS 5
`define SPM_REF_START_CYC ((`SPM_REF_START_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`endif

// ==== design/spm_sleep_ctrl.v ====
// sleep control, peripheral clock gating and analog power management with axi4-lite access
`timescale 1ns/1ps
`include "spm_consts.vh"
module spm_sleep_ctrl #(
  parameter NPINS = 16,
  parameter REF_START_CYC = `SPM_REF_START_CYC
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // core side
  input wire sleep_instr,
  input wire wake_event,
  input wire [2:0] brownout_threshold_fuses,
  input wire [NPINS-1:0] wake_pin_needed,
  // clock enables towards peripherals
  output reg cpu_clk_en,
  output reg io_clock_en,
  output reg converter_clock_en,
  output reg osc_en,
  output reg timer_one_clk_en,
  output reg timer_zero_clk_en,
  output reg serial_clk_en,
  output reg timer_one_regs_ok,
  output reg timer_zero_regs_ok,
  output reg serial_regs_ok,
  output reg converter_regs_ok,
  // analog power controls
  output reg converter_power,
  output reg converter_extended,
  output reg comparator_power,
  output reg brownout_active,
  output reg reference_on,
  output reg reference_ready,
  output reg watchdog_run,
  output reg [NPINS-1:0] pin_input_en,
  output reg asleep
);

  // sleep states
  localparam ST_RUN = 3'd0;
  localparam ST_IDLE = 3'd1;
  localparam ST_NOISE = 3'd2;
  localparam ST_PDOWN = 3'd3;
  localparam ST_STBY = 3'd4;

  reg [7:0] core_control_register;
  reg [7:0] peripheral_clock_gate;
  reg [7:0] analog_ctrl;
  reg [7:0] analog_pin_buffer_off_0;
  reg [7:0] analog_pin_buffer_off_1;
  reg [2:0] state;
  reg [2:0] next_state;
  reg conv_prev;
  reg [15:0] ref_cnt;
  reg [7:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  reg [31:0] rd_val;
  reg rd_ok;

  wire sleep_enable_bit = core_control_register[`SPM_CTRL_SE];
  wire [1:0] sleep_kind_field =
    core_control_register[`SPM_CTRL_SK_HI:`SPM_CTRL_SK_LO];
  wire conv_en = analog_ctrl[`SPM_ANA_CONV_EN];
  wire cmp_en = analog_ctrl[`SPM_ANA_CMP_EN];
  wire cmp_bg = analog_ctrl[`SPM_ANA_CMP_BG];
  wire bod_en = (brownout_threshold_fuses != 3'h7);
  wire deep = (state == ST_PDOWN) || (state == ST_STBY);
  wire io_run = (state == ST_RUN) || (state == ST_IDLE);
  wire adc_run = io_run || (state == ST_NOISE);
  // comparator power drops in deep sleep, but a comparator wired to the reference
  // keeps the reference alive in every sleep state
  wire cmp_live = cmp_en && !deep;
  wire ref_need = bod_en || (cmp_en && cmp_bg) || conv_en;
  wire [15:0] pins_off = {analog_pin_buffer_off_1, analog_pin_buffer_off_0};

  // sleep state machine
  // a wake event returns any sleep state straight to run
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (sleep_instr && sleep_enable_bit) begin
          case (sleep_kind_field)
            `SPM_SK_IDLE: next_state = ST_IDLE;
            `SPM_SK_NOISE: next_state = ST_NOISE;
            `SPM_SK_PDOWN: next_state = ST_PDOWN;
            default: next_state = ST_STBY;
          endcase
        end
      end
      ST_IDLE, ST_NOISE, ST_PDOWN, ST_STBY: begin
        if (wake_event)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge clk) begin
    if (srst)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // clock and power outputs, all registered from the current state, the control registers, the brown-out fuses and the wake pin inputs
  always @(posedge clk) begin
    if (srst) begin
      cpu_clk_en <= 1'b1;
      io_clock_en <= 1'b1;
      converter_clock_en <= 1'b1;
      osc_en <= 1'b1;
      timer_one_clk_en <= 1'b1;
      timer_zero_clk_en <= 1'b1;
      serial_clk_en <= 1'b1;
      timer_one_regs_ok <= 1'b1;
      timer_zero_regs_ok <= 1'b1;
      serial_regs_ok <= 1'b1;
      converter_regs_ok <= 1'b1;
      converter_power <= 1'b0;
      comparator_power <= 1'b0;
      brownout_active <= 1'b0;
      watchdog_run <= 1'b0;
      pin_input_en <= {NPINS{1'b1}};
      asleep <= 1'b0;
    end else begin
      cpu_clk_en <= (state == ST_RUN);
      io_clock_en <= io_run;
      converter_clock_en <= adc_run && !peripheral_clock_gate[`SPM_GATE_CONV];
      osc_en <= (state != ST_PDOWN);
      // gating stops the clock and blocks register access, so the timer keeps its state for resume
      timer_one_clk_en <= io_run && !peripheral_clock_gate[`SPM_GATE_TIM1];
      timer_zero_clk_en <= io_run && !peripheral_clock_gate[`SPM_GATE_TIM0];
      serial_clk_en <= io_run && !peripheral_clock_gate[`SPM_GATE_SER];
      timer_one_regs_ok <= !peripheral_clock_gate[`SPM_GATE_TIM1];
      timer_zero_regs_ok <= !peripheral_clock_gate[`SPM_GATE_TIM0];
      serial_regs_ok <= !peripheral_clock_gate[`SPM_GATE_SER];
      converter_regs_ok <= !peripheral_clock_gate[`SPM_GATE_CONV];
      converter_power <= conv_en;
      comparator_power <= cmp_live;
      brownout_active <= bod_en;
      watchdog_run <= analog_ctrl[`SPM_ANA_WDT_EN];
      // apart from the off registers, buffers drop only when both io and converter clocks are stopped
      pin_input_en <= ~pins_off[NPINS-1:0] &
        ((!io_run && !adc_run) ? wake_pin_needed : {NPINS{1'b1}});
      asleep <= (state != ST_RUN);
    end
  end

  // extended conversion flag: set when the converter is switched off, cleared once it runs
  always @(posedge clk) begin
    if (srst) begin
      conv_prev <= 1'b0;
      converter_extended <= 1'b1;
    end else begin
      conv_prev <= conv_en;
      // arming on switch-off lets software see the long conversion coming while idle
      if (!conv_en && conv_prev)
        converter_extended <= 1'b1;
      else if (conv_en && converter_clock_en)
        converter_extended <= 1'b0; // first clocked cycle marks the long conversion taken
    end
  end

  // reference enable and start-up timer; staying on keeps it ready through sleep
  // the counter restarts only once every user has let go of the reference
  always @(posedge clk) begin
    if (srst) begin
      reference_on <= 1'b0;
      reference_ready <= 1'b0;
      ref_cnt <= 16'h0000;
    end else begin
      reference_on <= ref_need;
      if (!ref_need) begin
        ref_cnt <= 16'h0000;
        reference_ready <= 1'b0;
      end else if (ref_cnt < REF_START_CYC[15:0]) begin
        ref_cnt <= ref_cnt + 16'h0001;
        reference_ready <= 1'b0;
      end else begin
        reference_ready <= 1'b1;
      end
    end
  end

  // write channel: take address and data in either order, answer when both are held
  always @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      core_control_register <= `SPM_CTRL_RST;
      peripheral_clock_gate <= `SPM_GATE_RST;
      analog_ctrl <= 8'h00;
      analog_pin_buffer_off_0 <= 8'h00;
      analog_pin_buffer_off_1 <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (w_strb[0]) begin
          case ({aw_addr[7:2], 2'b00})
            `SPM_ADDR_CTRL: core_control_register <= w_data[7:0] & `SPM_CTRL_MASK;
            `SPM_ADDR_GATE: peripheral_clock_gate <= w_data[7:0] & `SPM_GATE_MASK;
            `SPM_ADDR_ANA: analog_ctrl <= w_data[7:0] & `SPM_ANA_MASK;
            `SPM_ADDR_DIS0: analog_pin_buffer_off_0 <= w_data[7:0];
            `SPM_ADDR_DIS1: analog_pin_buffer_off_1 <= w_data[7:0];
            `SPM_ADDR_STAT: s_axi_bresp <= 2'h2;
            default: s_axi_bresp <= 2'h2;
          endcase
        // no low byte lane: nothing stored, the answer still depends on the address
        end else if (!((({aw_addr[7:2], 2'b00}) >= `SPM_ADDR_CTRL) &&
                       (({aw_addr[7:2], 2'b00}) <= `SPM_ADDR_STAT))) begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read decode
  always @* begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    case ({s_axi_araddr[7:2], 2'b00})
      `SPM_ADDR_CTRL: rd_val[7:0] = core_control_register & `SPM_CTRL_MASK;
      `SPM_ADDR_GATE: rd_val[7:0] = peripheral_clock_gate & `SPM_GATE_MASK;
      `SPM_ADDR_ANA: rd_val[7:0] = analog_ctrl;
      `SPM_ADDR_DIS0: rd_val[7:0] = analog_pin_buffer_off_0;
      `SPM_ADDR_DIS1: rd_val[7:0] = analog_pin_buffer_off_1;
      `SPM_ADDR_STAT: rd_val[7:0] = {reference_ready, reference_on, converter_extended,
                                     comparator_power, asleep, state};
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel: one cycle from address taken to data valid
  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // spm_sleep_ctrl

// ==== tb/spm_sleep_ctrl_checker.sv ====
// assertion checker for the sleep and clock gating block
`timescale 1ns/1ps
module spm_checker #(
  parameter NPINS = 16,
  parameter REF_START_CYC = 200
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // bus and core side
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire sleep_instr,
  input wire [2:0] brownout_threshold_fuses,
  input wire [NPINS-1:0] wake_pin_needed,
  // clock enables
  input wire cpu_clk_en,
  input wire io_clock_en,
  input wire converter_clock_en,
  input wire osc_en,
  input wire timer_one_clk_en,
  input wire timer_zero_clk_en,
  input wire serial_clk_en,
  input wire timer_one_regs_ok,
  input wire timer_zero_regs_ok,
  input wire serial_regs_ok,
  input wire converter_regs_ok,
  // analog side
  input wire brownout_active,
  input wire reference_on,
  input wire reference_ready,
  input wire [NPINS-1:0] pin_input_en,
  input wire asleep
);
  // one clock domain, so clocking and reset are stated once
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sleep_entry_cause_a: assert property ($rose(asleep) |-> $past(sleep_instr, 2))
    else $error("sleep entered without a sleep instruction");
  power_down_clocks_a: assert property (asleep && !osc_en |->
    !cpu_clk_en && !io_clock_en && !converter_clock_en) else $error("clock runs in power-down");
  input_buf_off_a: assert property (
    !io_clock_en && !converter_clock_en && converter_regs_ok |->
    (pin_input_en & ~wake_pin_needed) == '0) else $error("input buffer left on");
  brownout_kept_a: assert property (
    brownout_threshold_fuses != 3'h7 |-> ##[1:2] brownout_active)
    else $error("brown-out detector not active");
  ref_for_bod_a: assert property (brownout_active |-> ##[0:1] reference_on)
    else $error("reference off while detector needs it");
  ref_startup_a: assert property (
    $rose(reference_on) |-> !reference_ready ##1 !reference_ready)
    else $error("reference ready before start-up");
  ready_needs_ref_a: assert property (reference_ready |-> reference_on)
    else $error("reference ready while off");
  tim_one_frozen_a: assert property (!timer_one_regs_ok |-> !timer_one_clk_en)
    else $error("timer one clocked while registers blocked");
  tim_zero_frozen_a: assert property (!timer_zero_regs_ok |-> !timer_zero_clk_en)
    else $error("timer zero clocked while registers blocked");
  serial_frozen_a: assert property (!serial_regs_ok |-> !serial_clk_en)
    else $error("serial clocked while registers blocked");
  conv_frozen_a: assert property (!converter_regs_ok |-> !converter_clock_en)
    else $error("converter clocked while registers blocked");
  write_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
endmodule // spm_checker

bind spm_sleep_ctrl spm_checker #(.NPINS(NPINS), .REF_START_CYC(REF_START_CYC)) i_chk (
  .clk(clk), .srst(srst), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .sleep_instr(sleep_instr), .brownout_threshold_fuses(brownout_threshold_fuses),
  .wake_pin_needed(wake_pin_needed), .cpu_clk_en(cpu_clk_en), .io_clock_en(io_clock_en),
  .converter_clock_en(converter_clock_en), .osc_en(osc_en),
  .timer_one_clk_en(timer_one_clk_en), .timer_zero_clk_en(timer_zero_clk_en),
  .serial_clk_en(serial_clk_en), .timer_one_regs_ok(timer_one_regs_ok),
  .timer_zero_regs_ok(timer_zero_regs_ok), .serial_regs_ok(serial_regs_ok),
  .converter_regs_ok(converter_regs_ok), .brownout_active(brownout_active),
  .reference_on(reference_on), .reference_ready(reference_ready),
  .pin_input_en(pin_input_en), .asleep(asleep));

// ==== tb/testbench.sv ====
// self-checking testbench for the sleep and clock gating block
`timescale 1ns/1ps
`include "spm_consts.vh"
module testbench;
  logic clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, sleep_instr = 0, wake_event = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] brownout_threshold_fuses = 3'h7;
  logic [15:0] wake_pin_needed = 16'h0001;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic cpu_clk_en, io_clock_en, converter_clock_en, osc_en, timer_one_clk_en;
  logic timer_zero_clk_en, serial_clk_en, timer_one_regs_ok, timer_zero_regs_ok;
  logic serial_regs_ok, converter_regs_ok, converter_power, converter_extended;
  logic comparator_power, brownout_active, reference_on, reference_ready, watchdog_run, asleep;
  logic [15:0] pin_input_en;
  int mismatches = 0, check_count = 0;
  // short start-up count keeps the reference wait brief
  spm_sleep_ctrl #(.NPINS(16), .REF_START_CYC(8)) i_dut (.clk, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_instr, .wake_event,
    .brownout_threshold_fuses, .wake_pin_needed, .cpu_clk_en, .io_clock_en, .converter_clock_en,
    .osc_en, .timer_one_clk_en, .timer_zero_clk_en, .serial_clk_en, .timer_one_regs_ok,
    .timer_zero_regs_ok, .serial_regs_ok, .converter_regs_ok, .converter_power,
    .converter_extended, .comparator_power, .brownout_active, .reference_on, .reference_ready,
    .watchdog_run, .pin_input_en, .asleep);
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // settle outputs a step after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end while (!(aw && w));
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    s_axi_rready <= 0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  task automatic pulse_sleep;
    @(posedge clk);
    sleep_instr <= 1;
    @(posedge clk);
    sleep_instr <= 0;
    tick(3);
  endtask
  // wake, then drop the sleep enable as software should
  task automatic pulse_wake;
    @(posedge clk);
    wake_event <= 1;
    @(posedge clk);
    wake_event <= 0;
    tick(3);
    wr(`SPM_ADDR_CTRL, 32'h00, 2'b00);
  endtask
  task automatic t_reset;
    rd(`SPM_ADDR_CTRL, 32'h00, 2'b00);
    rd(`SPM_ADDR_GATE, 32'h00, 2'b00);
    chk({cpu_clk_en, io_clock_en, converter_clock_en, osc_en, asleep}, 5'h1E);
    chk(converter_extended, 1'b1);
  endtask
  // reserved bits and unmapped places
  task automatic t_fields;
    wr(`SPM_ADDR_CTRL, 32'hFF, 2'b00);
    rd(`SPM_ADDR_CTRL, 32'h7B, 2'b00);
    wr(`SPM_ADDR_CTRL, 32'h00, 2'b00);
    wr(`SPM_ADDR_GATE, 32'hFF, 2'b00);
    rd(`SPM_ADDR_GATE, 32'h0F, 2'b00);
    wr(`SPM_ADDR_GATE, 32'h00, 2'b00);
    rd(8'h00, 32'h00, 2'b10);
    wr(8'h00, 32'h05, 2'b10);
    wr(`SPM_ADDR_STAT, 32'h00, 2'b10);
  endtask
  task automatic t_gates;
    for (int b = 0; b < 4; b++) begin
      wr(`SPM_ADDR_GATE, 32'h1 << b, 2'b00);
      tick(2);
      chk({timer_one_clk_en, timer_zero_clk_en, serial_clk_en, converter_clock_en},
          4'(~(4'h1 << b)));
      chk({timer_one_regs_ok, timer_zero_regs_ok, serial_regs_ok, converter_regs_ok},
          4'(~(4'h1 << b)));
    end
    wr(`SPM_ADDR_GATE, 32'h00, 2'b00);
    tick(2);
    chk({timer_one_clk_en, timer_zero_clk_en, timer_one_regs_ok, timer_zero_regs_ok},
        4'hF);
  endtask
  task automatic t_extended;
    wr(`SPM_ADDR_ANA, 32'h01, 2'b00);
    tick(3);
    chk(converter_extended, 1'b0);
    wr(`SPM_ADDR_ANA, 32'h00, 2'b00);
    tick(3);
    chk(converter_extended, 1'b1);
  endtask
  task automatic t_kinds;
    wr(`SPM_ADDR_CTRL, 32'h10, 2'b00);
    pulse_sleep;
    chk({asleep, cpu_clk_en}, 2'b01);
    wr(`SPM_ADDR_ANA, 32'h0B, 2'b00);
    for (int k = 0; k < 4; k++) begin
      wr(`SPM_ADDR_CTRL, 32'h20 | (k << 3), 2'b00);
      pulse_sleep;
      chk({asleep, cpu_clk_en, io_clock_en, converter_clock_en, osc_en},
          {2'b10, k == 0, k < 2, k != 2});
      chk({comparator_power, converter_power, watchdog_run, reference_on},
          {k < 2, 3'b111});
      chk(pin_input_en, (k >= 2) ? 16'h0001 : 16'hFFFF);
      pulse_wake;
      chk(asleep, 1'b0);
    end
    wr(`SPM_ADDR_ANA, 32'h00, 2'b00);
  endtask
  task automatic t_reference;
    wr(`SPM_ADDR_ANA, 32'h06, 2'b00);
    tick(2);
    chk({reference_on, reference_ready}, 2'b10);
    tick(12);
    chk(reference_ready, 1'b1);
    wr(`SPM_ADDR_CTRL, 32'h30, 2'b00);
    pulse_sleep;
    chk({reference_on, reference_ready, comparator_power}, 3'b110);
    pulse_wake;
    wr(`SPM_ADDR_ANA, 32'h00, 2'b00);
    tick(3);
    chk(reference_on, 1'b0);
    @(posedge clk);
    brownout_threshold_fuses <= 3'h0;
    wr(`SPM_ADDR_CTRL, 32'h30, 2'b00);
    pulse_sleep;
    chk({brownout_active, reference_on, asleep}, 3'b111);
    pulse_wake;
    brownout_threshold_fuses <= 3'h7;
  endtask
  task automatic t_buffers;
    wr(`SPM_ADDR_DIS0, 32'h03, 2'b00);
    wr(`SPM_ADDR_DIS1, 32'h80, 2'b00);
    tick(2);
    chk(pin_input_en, 16'h7FFC);
    wr(`SPM_ADDR_DIS0, 32'h00, 2'b00);
    wr(`SPM_ADDR_DIS1, 32'h00, 2'b00);
  endtask
  // main sequence after eight reset cycles
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    t_reset;
    t_fields;
    t_gates;
    t_extended;
    t_kinds;
    t_reference;
    t_buffers;
    tally_and_finish;
  end
  // a hang counts against the run
  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
endmodule // testbench
